/* core/nscc_pkg.sv */
/*
 * nscc_pkg: constants and types for the byte-wide RAM with calendar clock.
 * Assumes a single 125 MHz clock and synchronous strobes from the host.
 */
package nscc_pkg;

    localparam int unsigned ADDR_W        = 11;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned RAM_DEPTH     = 2048;
    localparam int unsigned NREG          = 8;

    localparam logic [10:0] CLK_BASE      = 11'h7f8;
    localparam logic [2:0]  IDX_CTRL      = 3'h0;
    localparam logic [2:0]  IDX_SEC       = 3'h1;
    localparam logic [2:0]  IDX_MIN       = 3'h2;
    localparam logic [2:0]  IDX_HOUR      = 3'h3;
    localparam logic [2:0]  IDX_DAY       = 3'h4;
    localparam logic [2:0]  IDX_DATE      = 3'h5;
    localparam logic [2:0]  IDX_MONTH     = 3'h6;
    localparam logic [2:0]  IDX_YEAR      = 3'h7;

    localparam int unsigned BIT_WR_HALT   = 7;
    localparam int unsigned BIT_RD_HALT   = 6;
    localparam int unsigned BIT_OSC_STOP  = 7;

    localparam logic [7:0]  MASK_CTRL_CNT = 8'h3f;
    localparam logic [7:0]  MASK_SEC_CNT  = 8'h7f;
    localparam logic [7:0]  MASK_DAY_CNT  = 8'h07;

    localparam logic [7:0]  MAX_SEC       = 8'h59;
    localparam logic [7:0]  MAX_MIN       = 8'h59;
    localparam logic [7:0]  MAX_HOUR      = 8'h23;
    localparam logic [7:0]  MAX_DAY       = 8'h07;
    localparam logic [7:0]  MAX_MONTH     = 8'h12;
    localparam logic [7:0]  MAX_YEAR      = 8'h99;
    localparam logic [7:0]  MAX_CENT      = 8'h39;
    localparam logic [7:0]  MONTH_FEB     = 8'h02;

    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  RST_ONE       = 8'h01;
    localparam logic [7:0]  RST_CENT      = 8'h20;

    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_TIME_NS  = 1000000000;
    localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W         = 27;

    typedef logic [NREG-1:0][7:0] nscc_regs_t;

    typedef struct packed {
        nscc_regs_t        cnt;
        nscc_regs_t        vis;
        logic [DIV_W-1:0]  div;
        logic [7:0]        dq_out;
    } nscc_state_s;

endpackage : nscc_pkg

/* core/nscc_top.sv */
/*
 * nscc_top: 2k x 8 RAM whose top eight bytes are a BCD calendar clock.
 * Assumes host strobes are synchronous to clk; data pin split into in/out/oe.
 */
// Function
// RL1: a 2k x 8 byte memory whose top eight bytes are the clock registers, accessed like RAM.
// RL2: clock keeps BCD century, year, month, date, day, hours, minutes, seconds in 24-hour form.
// RL3: month length and leap years are handled automatically, correct up to 2100.
// RL4: running counters are separate from visible registers so host access never disturbs them.
// RL5: while power fail is high the device is deselected and ignores all reads and writes.
// RL6: while read halt (century bit 6) is 1 the visible registers hold the value at halt time.
// RL7: after read halt returns to 0 all visible registers refresh together within one second.
// RL8: the host keeps read halt at 0 for at least 500 us to be sure of a fresh copy.
// RL9: write halt (century bit 7) stops updates so the host can write new BCD time values.
// RL10: clearing write halt loads the written values into the counters and resumes counting.
// RL11: seconds bit 7 is an oscillator stop that halts counting when 1, at any time.
// RL12: a read drives the data pins when chip select and output enable are low, write enable high.
// RL13: a write happens whenever chip select and write enable are low, address held stable.
// RL14: the host writes 0 to all unused bits of the clock registers.
// RL15: data pins float when deselected, output enable high, or a write is in progress.
// RL16: a host clock write with no halt set touches only the visible copy, not the counters.
`timescale 1ns/100ps
module nscc_top
    import nscc_pkg::*;
#(
    parameter int unsigned TICK_CNT = TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              chip_sel_n,
    input  wire logic              out_en_n,
    input  wire logic              wr_en_n,
    input  wire logic              power_fail,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe
);

    logic [DATA_W-1:0] ram [RAM_DEPTH];
    nscc_state_s       st_reg;
    nscc_state_s       st_next;
    logic              sel;
    logic              wr_act;
    logic              rd_act;
    logic              is_clk;
    logic              osc_run;
    logic              tick;
    logic [7:0]        dim;
    logic              wrap_sec;
    logic              wrap_min;
    logic              wrap_hour;
    logic              wrap_day;
    logic              wrap_date;
    logic              wrap_mon;
    logic              wrap_year;
    logic              wrap_cent;
    nscc_regs_t        cnt_mask;
    nscc_regs_t        vis_fresh;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
        logic [6:0] ybin;
        ybin = 7'(yr[7:4]) * 7'h0a + 7'(yr[3:0]);
        unique case (mon)
            8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
            MONTH_FEB:                  days_in_month = (ybin[1:0] == 2'h0) ? 8'h29 : 8'h28;
            default:                    days_in_month = 8'h31;
        endcase
    endfunction : days_in_month

    assign sel    = !power_fail && !chip_sel_n;                     // RL5
    assign wr_act = sel && !wr_en_n;                                // RL13
    assign rd_act = sel && !out_en_n && wr_en_n;                    // RL12
    assign is_clk = (addr[ADDR_W-1:3] == CLK_BASE[ADDR_W-1:3]);     // RL1
    assign dq_oe  = rd_act;                                         // RL15
    assign dq_out = st_reg.dq_out;

    // carry chain of the running counters, one wrap flag per field
    assign osc_run   = !st_reg.vis[IDX_SEC][BIT_OSC_STOP];                  // RL11
    assign tick      = osc_run && (st_reg.div == DIV_W'(TICK_CNT - 1));
    assign dim       = days_in_month(st_reg.cnt[IDX_MONTH], st_reg.cnt[IDX_YEAR]);
    assign wrap_sec  = tick && (st_reg.cnt[IDX_SEC] == MAX_SEC);
    assign wrap_min  = wrap_sec && (st_reg.cnt[IDX_MIN] == MAX_MIN);
    assign wrap_hour = wrap_min && (st_reg.cnt[IDX_HOUR] == MAX_HOUR);
    assign wrap_day  = wrap_hour && (st_reg.cnt[IDX_DAY] == MAX_DAY);
    assign wrap_date = wrap_hour && (st_reg.cnt[IDX_DATE] == dim);          // RL3
    assign wrap_mon  = wrap_date && (st_reg.cnt[IDX_MONTH] == MAX_MONTH);
    assign wrap_year = wrap_mon && (st_reg.cnt[IDX_YEAR] == MAX_YEAR);
    assign wrap_cent = wrap_year && (st_reg.cnt[IDX_CTRL] == MAX_CENT);

    // per-register split between counted bits and bits kept from the host
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        if (g == int'(IDX_CTRL)) begin : g_ctrl
            assign cnt_mask[g] = MASK_CTRL_CNT;
        end else if (g == int'(IDX_SEC)) begin : g_sec
            assign cnt_mask[g] = MASK_SEC_CNT;
        end else if (g == int'(IDX_DAY)) begin : g_day
            assign cnt_mask[g] = MASK_DAY_CNT;
        end else begin : g_full
            assign cnt_mask[g] = '1;
        end
        assign vis_fresh[g] = (st_reg.vis[g] & ~cnt_mask[g]) | (st_reg.cnt[g] & cnt_mask[g]);
    end

    always_comb begin
        logic wr_was;
        st_next = st_reg;
        wr_was  = st_reg.vis[IDX_CTRL][BIT_WR_HALT];

        // timebase divider, held while the oscillator is stopped
        if (osc_run) begin                                              // RL11
            if (tick) begin
                st_next.div = '0;
            end else begin
                st_next.div = st_reg.div + DIV_W'(1);
            end
        end

        // counters run on their own, independent of host access
        if (tick) begin                                                 // RL4
            if (wrap_sec) begin
                st_next.cnt[IDX_SEC] = RST_ZERO;
            end else begin
                st_next.cnt[IDX_SEC] = bcd_inc(st_reg.cnt[IDX_SEC]);    // RL2
            end
        end
        if (wrap_sec) begin
            if (wrap_min) begin
                st_next.cnt[IDX_MIN] = RST_ZERO;
            end else begin
                st_next.cnt[IDX_MIN] = bcd_inc(st_reg.cnt[IDX_MIN]);
            end
        end
        if (wrap_min) begin
            if (wrap_hour) begin
                st_next.cnt[IDX_HOUR] = RST_ZERO;
            end else begin
                st_next.cnt[IDX_HOUR] = bcd_inc(st_reg.cnt[IDX_HOUR]);
            end
        end
        if (wrap_hour) begin
            if (wrap_day) begin
                st_next.cnt[IDX_DAY] = RST_ONE;
            end else begin
                st_next.cnt[IDX_DAY] = bcd_inc(st_reg.cnt[IDX_DAY]);
            end
        end
        if (wrap_hour) begin
            if (wrap_date) begin                                        // RL3
                st_next.cnt[IDX_DATE] = RST_ONE;
            end else begin
                st_next.cnt[IDX_DATE] = bcd_inc(st_reg.cnt[IDX_DATE]);
            end
        end
        if (wrap_date) begin
            if (wrap_mon) begin
                st_next.cnt[IDX_MONTH] = RST_ONE;
            end else begin
                st_next.cnt[IDX_MONTH] = bcd_inc(st_reg.cnt[IDX_MONTH]);
            end
        end
        if (wrap_mon) begin
            if (wrap_year) begin
                st_next.cnt[IDX_YEAR] = RST_ZERO;
            end else begin
                st_next.cnt[IDX_YEAR] = bcd_inc(st_reg.cnt[IDX_YEAR]);
            end
        end
        if (wrap_year) begin
            if (wrap_cent) begin
                st_next.cnt[IDX_CTRL] = RST_ZERO;
            end else begin
                st_next.cnt[IDX_CTRL] = bcd_inc(st_reg.cnt[IDX_CTRL]);
            end
        end

        // copy counts into the visible bank unless a halt is set; control bits stay
        if (!st_reg.vis[IDX_CTRL][BIT_RD_HALT] && !wr_was) begin            // RL6 RL7
            st_next.vis = vis_fresh;
        end

        // host write lands in the visible bank only
        if (wr_act && is_clk) begin                                     // RL9 RL16
            st_next.vis[addr[2:0]] = dq_in;
        end

        // falling write halt loads the visible bank into the counters
        if (wr_was && !st_next.vis[IDX_CTRL][BIT_WR_HALT]) begin        // RL10
            for (int i = 0; i < NREG; i++) begin
                st_next.cnt[i] = st_next.vis[i] & cnt_mask[i];
            end
            st_next.div            = '0;
        end

        if (rd_act) begin                                               // RL12
            st_next.dq_out = is_clk ? st_reg.vis[addr[2:0]] : ram[addr];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg                 <= '0;
            st_reg.cnt[IDX_CTRL]   <= RST_CENT;
            st_reg.cnt[IDX_DAY]    <= RST_ONE;
            st_reg.cnt[IDX_DATE]   <= RST_ONE;
            st_reg.cnt[IDX_MONTH]  <= RST_ONE;
            st_reg.vis[IDX_CTRL]   <= RST_CENT;
            st_reg.vis[IDX_DAY]    <= RST_ONE;
            st_reg.vis[IDX_DATE]   <= RST_ONE;
            st_reg.vis[IDX_MONTH]  <= RST_ONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // plain RAM bytes; the top eight live in the register banks instead
    always_ff @(posedge clk) begin
        if (wr_act && !is_clk) begin                                    // RL1 RL13
            ram[addr] <= dq_in;
        end
    end

endmodule : nscc_top

/* test/nscc_monitor.sv */
/* nscc_monitor: port assertions for nscc_top, bound at the foot.
   Assumes rising-edge sampling and a synchronous active-low reset. */
`timescale 1ns/100ps
module nscc_monitor
    import nscc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              chip_sel_n,
    input wire logic              out_en_n,
    input wire logic              wr_en_n,
    input wire logic              power_fail,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe
);
    logic rd, wr, rh_reg, wh_reg;
    assign rd = !power_fail && !chip_sel_n && !out_en_n && wr_en_n;
    assign wr = !power_fail && !chip_sel_n && !wr_en_n;
    // halt bits as last written by the host
    always_ff @(posedge clk) begin
        if (!rst_n) {wh_reg, rh_reg} <= 2'h0;
        else if (wr && addr == CLK_BASE) {wh_reg, rh_reg} <= dq_in[7:6];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence same_rd; rd && addr == $past(addr); endsequence
    sequence ram_rd; rd && addr < CLK_BASE; endsequence
    sequence pf_wr; power_fail && !chip_sel_n && !wr_en_n && addr == $past(addr); endsequence
    AST_OE_READ: assert property (dq_oe == rd)
        else $error("dq_oe not the read decode");
    AST_PF_FLOAT: assert property (power_fail |-> !dq_oe)
        else $error("driven while power fail");
    AST_WR_WINS: assert property (!chip_sel_n && !wr_en_n |-> !dq_oe)
        else $error("driven during write");
    AST_OUT_HOLD: assert property (!rd |=> $stable(dq_out))
        else $error("dq_out moved without read");
    AST_RAM_RW: assert property (
        wr && addr < CLK_BASE ##1 same_rd |=> dq_out == $past(dq_in, 2))
        else $error("ram byte not read back");
    AST_PF_NOWR: assert property (
        ram_rd ##1 pf_wr ##1 same_rd |=> dq_out == $past(dq_out, 2))
        else $error("write taken during power fail");
    AST_RD_HALT: assert property (
        rh_reg && rd && addr >= CLK_BASE ##1 same_rd |=> $stable(dq_out))
        else $error("clock byte moved under read halt");
    AST_WR_HALT: assert property (
        wh_reg && wr && addr > CLK_BASE ##1 same_rd |=> dq_out == $past(dq_in, 2))
        else $error("clock byte lost under write halt");
endmodule : nscc_monitor
bind nscc_top nscc_monitor mon_u (.clk(clk), .rst_n(rst_n), .addr(addr), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .power_fail(power_fail), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));

/* test/nscc_host.sv */
/* nscc_host: host model driving the byte-wide strobes of nscc_top.
   Assumes strobes change at falling clk and are sampled at rising clk. */
`timescale 1ns/100ps
module nscc_host
    import nscc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dq_out,
    output logic      [ADDR_W-1:0] addr,
    output logic                   chip_sel_n,
    output logic                   out_en_n,
    output logic                   wr_en_n,
    output logic      [DATA_W-1:0] dq_in
);
    initial {addr, chip_sel_n, out_en_n, wr_en_n, dq_in} = '1;
    // released lines show inverted values, never the last ones
    task automatic idle(input int n);
        {chip_sel_n, out_en_n, wr_en_n} = 3'h7;
        {addr, dq_in} = ~{addr, dq_in};
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        {addr, dq_in, chip_sel_n, out_en_n, wr_en_n} = {a, d, 3'h2};
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        {addr, chip_sel_n, out_en_n, wr_en_n} = {a, 3'h1};
        dq_in = ~dq_in;
        @(negedge clk);
        d = dq_out;
    endtask : rd
endmodule : nscc_host

/* test/nscc_top_test.sv */
/* nscc_top_test: self-checking bench for nscc_top with a scaled second.
   Assumes nscc_host as bus partner and nscc_monitor bound to the design. */
`timescale 1ns/100ps
module nscc_top_test
    import nscc_pkg::*;
    ;
    localparam int unsigned TICK = 64;
    localparam logic [6:0][7:0] RST_V = 56'h00010101000000;
    localparam logic [6:0][7:0] SET_V [5] = '{56'h24022803235958, 56'h23022807235958,
        56'h24043001235958, 56'h99123105235958, 56'h240430012359d8};
    localparam logic [6:0][7:0] EXP_V [5] = '{56'h24022904000000, 56'h23030101000000,
        56'h24050102000000, 56'h00010106000000, 56'h240430012359d8};
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              power_fail = 1'b0;
    logic              chip_sel_n, out_en_n, wr_en_n, dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_in, dq_out, got;
    logic [DATA_W-1:0] mem [int];
    int                failures = 0;
    int                comparisons = 0;
    int                a;
    always #4 clk = ~clk;
    nscc_top #(.TICK_CNT(TICK)) dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
        .power_fail(power_fail), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    nscc_host host_u (.clk(clk), .dq_out(dq_out), .addr(addr), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_in(dq_in));
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // tests take about eleven hundred cycles
    initial begin
        #100us;
        failures++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'he72d));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        host_u.idle(1);
        host_u.wr(CLK_BASE, 8'h60);
        for (int j = 0; j < 7; j++) begin
            host_u.rd(CLK_BASE + 11'(j + 1), got);
            check(got, RST_V[j]);
        end
        // back-to-back reads across several ticks keep the halt assertion busy
        repeat (3 * TICK) host_u.rd(CLK_BASE + 11'h1, got);
        check(got, 8'h00);
        $display("reset and read halt test done");
        repeat (16) begin
            a = $urandom_range(int'(CLK_BASE) - 1);
            mem[a] = 8'($urandom);
            host_u.wr(11'(a), mem[a]);
            host_u.rd(11'(a), got);
            check(got, mem[a]);
        end
        power_fail = 1'b1;
        host_u.wr(11'(a), ~mem[a]);
        power_fail = 1'b0;
        host_u.rd(11'(a), got);
        check(got, mem[a]);
        foreach (mem[k]) begin
            host_u.rd(11'(k), got);
            check(got, mem[k]);
        end
        $display("ram test done");
        for (int i = 0; i < 5; i++) begin
            host_u.wr(CLK_BASE, 8'ha0);
            for (int j = 0; j < 7; j++) host_u.wr(CLK_BASE + 11'(j + 1), SET_V[i][j]);
            host_u.rd(CLK_BASE + 11'h7, got);
            check(got, SET_V[i][6]);
            host_u.wr(CLK_BASE, 8'h20);
            host_u.wr(CLK_BASE + 11'h2, 8'h11);
            host_u.idle(2 * TICK + TICK / 2);
            host_u.wr(CLK_BASE, 8'h60);
            for (int j = 0; j < 7; j++) begin
                host_u.rd(CLK_BASE + 11'(j + 1), got);
                check(got, EXP_V[i][j]);
            end
            $display("calendar case %0d done", i);
        end
        print_verdict();
    end
endmodule : nscc_top_test
